// ---- design/pfe_pkg.sv ----
// package: register map, field layout and reset values of the pin filter and event block
package pfe_pkg;
  localparam int PFE_LINES = 32;
  localparam int PFE_AW = 8;
  // ==============================
  // register offsets (byte addresses)
  localparam logic [7:0] PFE_FILTER_ON_REG = 8'h20;
  localparam logic [7:0] PFE_FILTER_OFF_REG = 8'h24;
  localparam logic [7:0] PFE_FILTER_ACTIVE_STATE = 8'h28;
  localparam logic [7:0] PFE_PIN_LEVEL_READBACK = 8'h3c;
  localparam logic [7:0] PFE_IRQ_ON_REG = 8'h40;
  localparam logic [7:0] PFE_IRQ_OFF_REG = 8'h44;
  localparam logic [7:0] PFE_IRQ_MASK_STATE = 8'h48;
  localparam logic [7:0] PFE_EVENT_PENDING_WORD = 8'h4c;
  localparam logic [7:0] PFE_FILTER_SLOWCLK_OFF_REG = 8'h80;
  localparam logic [7:0] PFE_FILTER_SLOWCLK_ON_REG = 8'h84;
  localparam logic [7:0] PFE_FILTER_SOURCE_STATE = 8'h88;
  localparam logic [7:0] PFE_DEBOUNCE_PRESCALE_REG = 8'h8c;
  localparam logic [7:0] PFE_EXTRA_MODE_ON_REG = 8'hb0;
  localparam logic [7:0] PFE_EXTRA_MODE_OFF_REG = 8'hb4;
  localparam logic [7:0] PFE_EXTRA_MODE_STATE = 8'hb8;
  localparam logic [7:0] PFE_EDGE_CHOOSE_REG = 8'hc0;
  localparam logic [7:0] PFE_LEVEL_CHOOSE_REG = 8'hc4;
  localparam logic [7:0] PFE_EDGE_LEVEL_STATE = 8'hc8;
  localparam logic [7:0] PFE_FALL_LOW_CHOOSE_REG = 8'hd0;
  localparam logic [7:0] PFE_RISE_HIGH_CHOOSE_REG = 8'hd4;
  localparam logic [7:0] PFE_POLARITY_STATE = 8'hd8;
  localparam logic [7:0] PFE_PROTECT_MODE_REG = 8'he4;
  localparam logic [7:0] PFE_PROTECT_STATUS_REG = 8'he8;
  // schmitt enable pair and status
  localparam logic [7:0] PFE_SCHMITT_OFF_REG = 8'hf0;
  localparam logic [7:0] PFE_SCHMITT_ON_REG = 8'hf4;
  localparam logic [7:0] PFE_SCHMITT_STATE = 8'hf8;
  // ==============================
  // protected offsets owned by neighbouring blocks (controller, mux, pulls, etc.)
  localparam logic [7:0] PFE_PROT_LINE_CTL_ON = 8'h00;
  localparam logic [7:0] PFE_PROT_LINE_CTL_OFF = 8'h04;
  localparam logic [7:0] PFE_PROT_DRIVE_ON = 8'h10;
  localparam logic [7:0] PFE_PROT_DRIVE_OFF = 8'h14;
  localparam logic [7:0] PFE_PROT_OPEN_DRAIN_ON = 8'h50;
  localparam logic [7:0] PFE_PROT_OPEN_DRAIN_OFF = 8'h54;
  localparam logic [7:0] PFE_PROT_PULLUP_OFF = 8'h60;
  localparam logic [7:0] PFE_PROT_PULLUP_ON = 8'h64;
  localparam logic [7:0] PFE_PROT_SEL1 = 8'h70;
  localparam logic [7:0] PFE_PROT_SEL2 = 8'h74;
  localparam logic [7:0] PFE_PROT_PULLDN_OFF = 8'h90;
  localparam logic [7:0] PFE_PROT_PULLDN_ON = 8'h94;
  localparam logic [7:0] PFE_PROT_SYNC_WR_ON = 8'ha0;
  localparam logic [7:0] PFE_PROT_SYNC_WR_OFF = 8'ha4;
  // ==============================
  // fields
  localparam int PFE_DIV_W = 14;
  localparam int PFE_PROT_ON_BIT = 0;
  localparam int PFE_KEY_LSB = 8;
  localparam int PFE_KEY_W = 24;
  localparam logic [23:0] PFE_PROT_KEY = 24'ha5c35a; // arbitrary unlock key value
  localparam int PFE_VIOL_FLAG_BIT = 0;
  localparam int PFE_VIOL_SRC_LSB = 8;
  localparam int PFE_VIOL_SRC_W = 16;
  // ==============================
  // reset values
  localparam logic [31:0] PFE_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] PFE_RST_SCHMITT = 32'hffff_ffff;
  localparam logic [PFE_DIV_W-1:0] PFE_RST_DIV = 14'h0000;
  // ==============================
  // timing: peripheral clock and slow clock rates
  localparam int PFE_CLK_HZ = 10_000_000;
  localparam int PFE_SLCK_HZ = 32_768;
endpackage

// ---- design/pfe_top.sv ----
// pin input filter, change detection and write protection for a 32-line io controller
`timescale 1ns/1ps
// Notes on behaviour
// - each line may filter glitches (fast clock) or debounce pulses (divided slow clock)
// - filter source bit: 0 glitch on fast clock, 1 debounce on slow divided clock
// - debounce period is slow clock period times (prescale plus one)
// - pulses under one selected cycle rejected, two full cycles or more accepted
// - filter on/off registers set and clear the per-line filter active bits
// - filters never touch the raw input passed to on-chip peripherals
// - irq on/off registers set and clear the read-only interrupt mask
// - change detection compares two consecutive fast-clock samples of each line
// - change detection works on every line whatever its configuration
// - without extra modes, any rising or falling edge is an event
// - extra modes switched on and off per line, state readable
// - edge or level detection chosen per line by two write registers
// - polarity chosen by fall/low or rise/high register, meaning follows edge/level
// - event sets pending bit; masked pending bit drives the interrupt output
// - all line requests are ORed into one interrupt output
// - reading the pending word clears at once every pending bit whose line has no event in that cycle
// - level events keep reporting while the level persists, even after reads
// - schmitt trigger enable per line, on after reset, can be disabled
// - protect bit blocks writes to the listed configuration registers
// - blocked write sets a violation flag and records the target offset
// - reading protection status clears the violation flag
// - pin level readback shows the filtered level for lines with the filter active, the synchronised pin for the others
module pfe_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // slow clock pulse, asynchronous square wave
  input wire logic slow_clk_in,
  // pads
  input wire logic [pfe_pkg::PFE_LINES-1:0] pad_in,
  output logic [pfe_pkg::PFE_LINES-1:0] periph_in,
  output logic [pfe_pkg::PFE_LINES-1:0] schmitt_en,
  // register port
  input wire logic [pfe_pkg::PFE_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // write enable seen by neighbouring blocks for protected offsets
  output logic prot_wr_ok,
  // interrupt to system controller
  output logic irq
);
  import pfe_pkg::*;

  // ==============================
  // input synchronisers
  logic [PFE_LINES-1:0] pad_s1_q, pad_s2_q, samp_q;
  logic slck_s1_q, slck_s2_q, slck_prev_q;
  always_ff @(posedge ref_clk) begin
    pad_s1_q <= pad_in;
    pad_s2_q <= pad_s1_q;
    slck_s1_q <= slow_clk_in;
    slck_s2_q <= slck_s1_q;
    slck_prev_q <= slck_s2_q;
  end
  // peripherals see the synchronised pin, never the filtered one
  assign periph_in = pad_s2_q;

  // ==============================
  // configuration registers
  logic [PFE_LINES-1:0] filt_act_q, filt_src_q, mask_q, extra_q, lvl_q, pol_q, schm_q;
  logic [PFE_DIV_W-1:0] div_q;
  logic prot_on_q, viol_q;
  logic [PFE_VIOL_SRC_W-1:0] viol_src_q;
  logic wr_is_prot;
  // filter source pair is left writable: only the listed offsets are guarded
  assign wr_is_prot = reg_wr && (reg_addr inside {
    PFE_PROT_LINE_CTL_ON,
    PFE_PROT_LINE_CTL_OFF,
    PFE_PROT_DRIVE_ON,
    PFE_PROT_DRIVE_OFF,
    PFE_FILTER_ON_REG,
    PFE_FILTER_OFF_REG,
    PFE_PROT_OPEN_DRAIN_ON,
    PFE_PROT_OPEN_DRAIN_OFF,
    PFE_PROT_PULLUP_OFF,
    PFE_PROT_PULLUP_ON,
    PFE_PROT_SEL1,
    PFE_PROT_SEL2,
    PFE_PROT_PULLDN_OFF,
    PFE_PROT_PULLDN_ON,
    PFE_PROT_SYNC_WR_ON,
    PFE_PROT_SYNC_WR_OFF});
  logic blocked;
  assign blocked = wr_is_prot && prot_on_q;
  assign prot_wr_ok = !prot_on_q;
  function automatic logic hit(input logic [7:0] off);
    return reg_wr && (reg_addr == off);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      filt_act_q <= PFE_RST_ZERO;
    end else if (!blocked) begin
      if (hit(PFE_FILTER_ON_REG)) begin
        filt_act_q <= filt_act_q | reg_wdata;
      end else if (hit(PFE_FILTER_OFF_REG)) begin
        filt_act_q <= filt_act_q & ~reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      filt_src_q <= PFE_RST_ZERO;
      div_q <= PFE_RST_DIV;
    end else begin
      if (hit(PFE_FILTER_SLOWCLK_ON_REG)) begin
        filt_src_q <= filt_src_q | reg_wdata;
      end else if (hit(PFE_FILTER_SLOWCLK_OFF_REG)) begin
        filt_src_q <= filt_src_q & ~reg_wdata;
      end
      if (hit(PFE_DEBOUNCE_PRESCALE_REG)) begin
        div_q <= reg_wdata[PFE_DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_q <= PFE_RST_ZERO;
    end else if (hit(PFE_IRQ_ON_REG)) begin
      mask_q <= mask_q | reg_wdata;
    end else if (hit(PFE_IRQ_OFF_REG)) begin
      mask_q <= mask_q & ~reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      extra_q <= PFE_RST_ZERO;
      lvl_q <= PFE_RST_ZERO;
      pol_q <= PFE_RST_ZERO;
    end else begin
      if (hit(PFE_EXTRA_MODE_ON_REG)) begin
        extra_q <= extra_q | reg_wdata;
      end else if (hit(PFE_EXTRA_MODE_OFF_REG)) begin
        extra_q <= extra_q & ~reg_wdata;
      end
      if (hit(PFE_LEVEL_CHOOSE_REG)) begin
        lvl_q <= lvl_q | reg_wdata;
      end else if (hit(PFE_EDGE_CHOOSE_REG)) begin
        lvl_q <= lvl_q & ~reg_wdata;
      end
      if (hit(PFE_RISE_HIGH_CHOOSE_REG)) begin
        pol_q <= pol_q | reg_wdata;
      end else if (hit(PFE_FALL_LOW_CHOOSE_REG)) begin
        pol_q <= pol_q & ~reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      schm_q <= PFE_RST_SCHMITT;
    end else if (hit(PFE_SCHMITT_ON_REG)) begin
      schm_q <= schm_q | reg_wdata;
    end else if (hit(PFE_SCHMITT_OFF_REG)) begin
      schm_q <= schm_q & ~reg_wdata;
    end
  end
  assign schmitt_en = schm_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prot_on_q <= 1'b0;
    end else if (hit(PFE_PROTECT_MODE_REG) &&
                 reg_wdata[PFE_KEY_LSB +: PFE_KEY_W] == PFE_PROT_KEY) begin
      prot_on_q <= reg_wdata[PFE_PROT_ON_BIT];
    end
  end

  // violation flag: a new violation wins over the clearing read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      viol_q <= 1'b0;
      viol_src_q <= '0;
    end else if (blocked) begin
      viol_q <= 1'b1;
      viol_src_q <= {8'h00, reg_addr};
    end else if (reg_rd && reg_addr == PFE_PROTECT_STATUS_REG) begin
      viol_q <= 1'b0;
    end
  end

  // ==============================
  // debounce tick: one pulse every prescale plus one slow clock periods
  // slow edges counted on the fast clock, so slow clock must be far slower
  logic [PFE_DIV_W-1:0] dcnt_q;
  logic dtick;
  logic slck_rise;
  assign slck_rise = slck_s2_q && !slck_prev_q;
  assign dtick = slck_rise && (dcnt_q == div_q);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dcnt_q <= '0;
    end else if (slck_rise) begin
      dcnt_q <= (dcnt_q == div_q) ? '0 : dcnt_q + 1'b1;
    end
  end

  // ==============================
  // per-line filter: new level must be stable for two sampling ticks before it is taken
  logic [PFE_LINES-1:0] cand_q, filt_q, filt_lvl;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cand_q <= PFE_RST_ZERO;
      filt_q <= PFE_RST_ZERO;
    end else begin
      for (int i = 0; i < PFE_LINES; i++) begin
        // tick is every fast cycle for glitch mode, the divided slow tick for debounce
        if (!filt_src_q[i] || dtick) begin
          cand_q[i] <= pad_s2_q[i];
          if (cand_q[i] == pad_s2_q[i]) begin
            filt_q[i] <= pad_s2_q[i];
          end
        end
      end
    end
  end
  assign filt_lvl = (filt_act_q & filt_q) | (~filt_act_q & pad_s2_q);

  // ==============================
  // event detection on the filtered level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      samp_q <= PFE_RST_ZERO;
    end else begin
      samp_q <= filt_lvl;
    end
  end
  logic [PFE_LINES-1:0] rise, fall, evt, pend_q;
  assign rise = filt_lvl & ~samp_q;
  assign fall = ~filt_lvl & samp_q;
  // no gating by line configuration: every line is watched
  assign evt = (~extra_q & (rise | fall))
             | (extra_q & ~lvl_q & ((pol_q & rise) | (~pol_q & fall)))
             | (extra_q & lvl_q & ((pol_q & filt_lvl) | (~pol_q & ~filt_lvl)));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_q <= PFE_RST_ZERO;
    end else if (reg_rd && reg_addr == PFE_EVENT_PENDING_WORD) begin
      pend_q <= evt;
    end else begin
      pend_q <= pend_q | evt;
    end
  end
  assign irq = |(pend_q & mask_q);

  // ==============================
  // read data, valid the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= PFE_RST_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        PFE_FILTER_ACTIVE_STATE: reg_rdata <= filt_act_q;
        PFE_PIN_LEVEL_READBACK: reg_rdata <= filt_lvl;
        PFE_IRQ_MASK_STATE: reg_rdata <= mask_q;
        PFE_EVENT_PENDING_WORD: reg_rdata <= pend_q;
        PFE_FILTER_SOURCE_STATE: reg_rdata <= filt_src_q;
        PFE_DEBOUNCE_PRESCALE_REG: reg_rdata <= {18'h00000, div_q};
        PFE_EXTRA_MODE_STATE: reg_rdata <= extra_q;
        PFE_EDGE_LEVEL_STATE: reg_rdata <= lvl_q;
        PFE_POLARITY_STATE: reg_rdata <= pol_q;
        PFE_PROTECT_MODE_REG: reg_rdata <= {31'h00000000, prot_on_q};
        PFE_PROTECT_STATUS_REG: reg_rdata <= {8'h00, viol_src_q, 7'h00, viol_q};
        PFE_SCHMITT_STATE: reg_rdata <= schm_q;
        default: reg_rdata <= PFE_RST_ZERO;
      endcase
    end
  end
endmodule // pfe_top

// ---- verif/pfe_checker.sv ----
// checker: port level assertions for the pin filter and event block
`timescale 1ns/1ps
module pfe_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pads
  input wire logic slow_clk_in,
  input wire logic [pfe_pkg::PFE_LINES-1:0] pad_in,
  input wire logic [pfe_pkg::PFE_LINES-1:0] periph_in,
  input wire logic [pfe_pkg::PFE_LINES-1:0] schmitt_en,
  // register port
  input wire logic [pfe_pkg::PFE_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // status
  input wire logic prot_wr_ok,
  input wire logic irq
);
  import pfe_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==============================
  // assertions
  property p_raw;
    periph_in == $past(pad_in, 2);
  endproperty
  a_raw: assert property (p_raw) else $error("raw path wrong");
  property p_off;
    reg_wr && reg_addr == PFE_IRQ_OFF_REG && reg_wdata == 32'hffff_ffff |=> !irq;
  endproperty
  a_off: assert property (p_off) else $error("irq with empty mask");
  property p_sch_off;
    reg_wr && reg_addr == PFE_SCHMITT_OFF_REG |=> (schmitt_en & $past(reg_wdata)) == 32'h0;
  endproperty
  a_sch_off: assert property (p_sch_off) else $error("schmitt not off");
  property p_sch_on;
    reg_wr && reg_addr == PFE_SCHMITT_ON_REG |=> &(schmitt_en | ~$past(reg_wdata));
  endproperty
  a_sch_on: assert property (p_sch_on) else $error("schmitt not on");
  property p_lock;
    reg_wr && reg_addr == PFE_PROTECT_MODE_REG && reg_wdata[31:8] == PFE_PROT_KEY
      && reg_wdata[0] |=> !prot_wr_ok;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not taken");
  property p_unlock;
    reg_wr && reg_addr == PFE_PROTECT_MODE_REG && reg_wdata[31:8] == PFE_PROT_KEY
      && !reg_wdata[0] |=> prot_wr_ok;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock not taken");
  property p_unmap;
    reg_rd && reg_addr == 8'hfc |=> reg_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_viol;
    (reg_wr && reg_addr == PFE_FILTER_ON_REG && !prot_wr_ok) ##1 !reg_wr
      ##1 (reg_rd && reg_addr == PFE_PROTECT_STATUS_REG) |=> reg_rdata[23:0] == 24'h0020_01;
  endproperty
  a_viol: assert property (p_viol) else $error("violation not logged");
  property p_vclr;
    (reg_rd && reg_addr == PFE_PROTECT_STATUS_REG) ##1 !reg_wr
      ##1 (reg_rd && reg_addr == PFE_PROTECT_STATUS_REG) |=> !reg_rdata[0];
  endproperty
  a_vclr: assert property (p_vclr) else $error("violation flag kept");
  property p_mask;
    (reg_wr && reg_addr == PFE_IRQ_ON_REG) ##1 !reg_wr ##1 (reg_rd && reg_addr ==
      PFE_IRQ_MASK_STATE) |=> (reg_rdata & $past(reg_wdata, 3)) == $past(reg_wdata, 3);
  endproperty
  a_mask: assert property (p_mask) else $error("mask bits not set");
  c_irq: cover property ($rose(irq));
  c_viol: cover property (reg_rd && reg_addr == PFE_PROTECT_STATUS_REG ##1 reg_rdata[0]);
  c_sch: cover property ($fell(schmitt_en[0]));
endmodule // pfe_checker

bind pfe_top pfe_checker u_chk (.ref_clk(ref_clk), .rst(rst), .slow_clk_in(slow_clk_in),
  .pad_in(pad_in), .periph_in(periph_in), .schmitt_en(schmitt_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .prot_wr_ok(prot_wr_ok), .irq(irq));

// ---- verif/pfe_pad_model.sv ----
// pad side model: pin levels, short glitches and the free running slow clock
`timescale 1ns/1ps
module pfe_pad_model (
  // wanted levels and glitches laid on top
  input wire logic [pfe_pkg::PFE_LINES-1:0] lvl,
  input wire logic [pfe_pkg::PFE_LINES-1:0] glitch,
  // pad side
  output logic [pfe_pkg::PFE_LINES-1:0] pad_in,
  output logic slow_clk_in
);
  import pfe_pkg::*;
  localparam int SLCK_HALF_NS = 1_000_000_000 / (2 * PFE_SLCK_HZ);
  // the slow oscillator never stops, so it runs free here too
  initial slow_clk_in = 1'b0;
  always #(SLCK_HALF_NS) slow_clk_in = ~slow_clk_in;
  assign pad_in = lvl ^ glitch;
endmodule // pfe_pad_model

// ---- verif/tb.sv ----
// testbench: register pairs, event detection, glitch filter and write protection
`timescale 1ns/1ps
module tb;
  import pfe_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [PFE_AW-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] lvl = 32'h0;
  logic [31:0] gl = 32'h0;
  logic [31:0] pad_in, periph_in, schmitt_en, reg_rdata, got, r, o;
  logic slow_clk_in, prot_wr_ok, irq;
  logic [31:0] m [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hffff_ffff};
  logic [7:0] grp [6][3] = '{'{8'h40, 8'h44, 8'h48}, '{8'h20, 8'h24, 8'h28},
    '{8'hb0, 8'hb4, 8'hb8}, '{8'hc4, 8'hc0, 8'hc8}, '{8'hd4, 8'hd0, 8'hd8},
    '{8'hf4, 8'hf0, 8'hf8}};
  int err_total = 0;
  int total_checks = 0;
  int g;
  integer seed = 32'h282d;
  // the detector and filters live on this clock, so it never stops
  always #50 ref_clk = ~ref_clk;
  pfe_pad_model pads (.lvl(lvl), .glitch(gl), .pad_in(pad_in), .slow_clk_in(slow_clk_in));
  pfe_top uut (.ref_clk(ref_clk), .rst(rst), .slow_clk_in(slow_clk_in), .pad_in(pad_in),
    .periph_in(periph_in), .schmitt_en(schmitt_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .prot_wr_ok(prot_wr_ok), .irq(irq));
  // ==============================
  // tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    got = reg_rdata;
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  function automatic logic [31:0] any_edge(input logic [31:0] a, input logic [31:0] b);
    return a ^ b;
  endfunction
  task close_out;
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==============================
  // main sequence
  initial begin
    wait_cyc(5);
    rst <= 1'b0;
    rd(PFE_SCHMITT_STATE); chk("schmitt reset", got, PFE_RST_SCHMITT);
    rd(8'hfc); chk("unmapped", got, 32'h0);
    // random set and clear pairs against a model of each state word
    for (int k = 0; k < 24; k++) begin
      g = k % 6;
      r = $random(seed); wr(grp[g][0], r); m[g] = m[g] | r;
      r = $random(seed); wr(grp[g][1], r); m[g] = m[g] & ~r;
      rd(grp[g][2]); chk("state word", got, m[g]);
    end
    chk("schmitt pins", schmitt_en, m[5]);
    // any edge detection, clear on read
    wr(PFE_IRQ_ON_REG, 32'hffff_ffff);
    rd(PFE_IRQ_MASK_STATE); chk("mask", got, 32'hffff_ffff);
    wr(PFE_FILTER_OFF_REG, 32'hffff_ffff);
    wr(PFE_EXTRA_MODE_OFF_REG, 32'hffff_ffff);
    rd(PFE_EVENT_PENDING_WORD);
    for (int k = 0; k < 6; k++) begin
      r = (k == 0) ? 32'h0 : $random(seed);
      o = lvl;
      @(posedge ref_clk) lvl <= lvl ^ r;
      wait_cyc(4);
      @(negedge ref_clk) chk("irq", {31'h0, irq}, {31'h0, r != 32'h0});
      chk("raw", periph_in, lvl);
      rd(PFE_EVENT_PENDING_WORD); chk("pending", got, any_edge(o, lvl));
      rd(PFE_PIN_LEVEL_READBACK); chk("level", got, lvl);
      rd(PFE_EVENT_PENDING_WORD); chk("cleared", got, 32'h0);
    end
    // extra modes on lines 0..7: rising, falling, low and high level
    @(posedge ref_clk) lvl <= 32'h8;
    wr(PFE_EXTRA_MODE_ON_REG, 32'hff);
    wr(PFE_LEVEL_CHOOSE_REG, 32'h38);
    wr(PFE_EDGE_CHOOSE_REG, 32'hffff_ffc7);
    wr(PFE_RISE_HIGH_CHOOSE_REG, 32'hb5);
    wr(PFE_FALL_LOW_CHOOSE_REG, 32'hffff_ff4a);
    rd(PFE_EVENT_PENDING_WORD);
    @(posedge ref_clk) lvl <= 32'hff;
    wait_cyc(4);
    rd(PFE_EVENT_PENDING_WORD); chk("rise high", got, 32'hb5);
    rd(PFE_EVENT_PENDING_WORD); chk("high held", got, 32'h30);
    @(posedge ref_clk) lvl <= 32'h0;
    wait_cyc(4);
    rd(PFE_EVENT_PENDING_WORD); chk("fall low", got, 32'h7a);
    rd(PFE_EVENT_PENDING_WORD); chk("low held", got, 32'h08);
    wr(PFE_EXTRA_MODE_OFF_REG, 32'hffff_ffff);
    // glitch filter on line 9 only; line 10 unfiltered sees the same glitch
    wr(PFE_FILTER_ON_REG, 32'h200);
    rd(PFE_EVENT_PENDING_WORD);
    @(posedge ref_clk) #80 gl = 32'h600;
    @(posedge ref_clk) #10 gl = 32'h0;
    wait_cyc(5);
    rd(PFE_EVENT_PENDING_WORD); chk("glitch", got, 32'h400);
    @(posedge ref_clk) lvl <= 32'h200;
    wait_cyc(3);
    lvl <= 32'h0;
    wait_cyc(5);
    rd(PFE_EVENT_PENDING_WORD); chk("long pulse", got, 32'h200);
    // write protection
    wr(PFE_PROTECT_MODE_REG, {PFE_PROT_KEY, 8'h01});
    wr(PFE_FILTER_ON_REG, 32'h1);
    rd(PFE_PROTECT_STATUS_REG); chk("viol", got & 32'hff_ffff, 32'h2001);
    rd(PFE_PROTECT_STATUS_REG); chk("viol clr", got & 32'h1, 32'h0);
    rd(PFE_FILTER_ACTIVE_STATE); chk("locked", got, 32'h200);
    wr(PFE_PROTECT_MODE_REG, {PFE_PROT_KEY, 8'h00});
    wr(PFE_FILTER_ON_REG, 32'h1);
    rd(PFE_FILTER_ACTIVE_STATE); chk("unlocked", got, 32'h201);
    // debounce on line 11, prescale 1: one tick every two slow clock periods
    wr(PFE_DEBOUNCE_PRESCALE_REG, 32'h1);
    wr(PFE_FILTER_SLOWCLK_ON_REG, 32'h800);
    wr(PFE_FILTER_ON_REG, 32'h800);
    rd(PFE_DEBOUNCE_PRESCALE_REG); chk("prescale", got, 32'h1);
    rd(PFE_FILTER_SOURCE_STATE); chk("source", got, 32'h800);
    @(posedge ref_clk) lvl <= 32'h800;
    wait_cyc(500);
    lvl <= 32'h0;
    wait_cyc(1300);
    rd(PFE_EVENT_PENDING_WORD); chk("debounce short", got, 32'h0);
    @(posedge ref_clk) lvl <= 32'h800;
    wait_cyc(1300);
    rd(PFE_PIN_LEVEL_READBACK); chk("debounce level", got, 32'h800);
    chk("irq up", {31'h0, irq}, 32'h1);
    wr(PFE_IRQ_OFF_REG, 32'hffff_ffff);
    @(negedge ref_clk) chk("irq off", {31'h0, irq}, 32'h0);
    @(posedge ref_clk) lvl <= 32'h0;
    wait_cyc(1300);
    rd(PFE_EVENT_PENDING_WORD); chk("debounce long", got, 32'h800);
    close_out;
  end
  initial begin
    #(100 * 20000);
    err_total++;
    close_out;
  end
endmodule // tb
